// ===== rtl/dead_band_pkg.sv
// dead-band stage constants: register map, field layout, reset values, source codes
// assumes a plain register port with 8-bit address and 16-bit data
package dead_band_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int CNT_W  = 10;

	localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h0e;
	localparam logic [ADDR_W-1:0] OFF_CONTROL  = 8'h0f;
	localparam logic [ADDR_W-1:0] OFF_LE_COUNT = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_TE_COUNT = 8'h11;

	localparam int CTL_OUT_MODE_LSB = 0;
	localparam int CTL_INV_LSB      = 2;
	localparam int CTL_IN_MODE_LSB  = 4;
	localparam int CTL_PRESCALE_LSB = 6;
	localparam int CTL_HALF_CYCLE   = 15;

	localparam logic [DATA_W-1:0] CTL_MASK      = 16'h80ff;
	localparam logic [DATA_W-1:0] CTL_RESET     = 16'h0000;
	localparam logic [CNT_W-1:0]  COUNT_RESET   = 10'h000;
	localparam logic [CNT_W-1:0]  COUNT_MAX     = 10'h3ff;

	localparam logic [1:0] OUT_BYPASS  = 2'b00;
	localparam logic [1:0] OUT_TE_ONLY = 2'b01;
	localparam logic [1:0] OUT_LE_ONLY = 2'b10;
	localparam logic [1:0] OUT_BOTH    = 2'b11;

	typedef enum logic [1:0] {
		SRC_A_BOTH     = 2'b00,
		SRC_B_LE_A_TE  = 2'b01,
		SRC_A_LE_B_TE  = 2'b10,
		SRC_B_BOTH     = 2'b11
	} in_mode_t;

	localparam int PRESCALE_W = 3;

endpackage

// ===== rtl/timebase_divider.sv
// time-base tick generator: full-period and half-period enables from clk_sys
// assumes div_sel is a software-held level on the same clock
`timescale 1ns/100ps
`default_nettype none
module timebase_divider
	import dead_band_pkg::*;
(
	input  wire logic       clk_sys,   // system clock
	input  wire logic       srst,      // synchronous reset
	input  wire logic [1:0] div_sel,   // divide by 1, 2, 4 or 8
	output logic            full_tick, // one time-base period
	output logic            half_tick  // every half time-base period, every period with divide by 1
);

	logic [PRESCALE_W-1:0] cnt_r;
	logic [PRESCALE_W-1:0] last;

	assign last      = PRESCALE_W'((4'h1 << div_sel) - 4'h1);
	assign full_tick = (cnt_r >= last);
	// with divide by 1 the half tick cannot be finer than clk_sys
	assign half_tick = full_tick || ((cnt_r == (last >> 1)) && (div_sel != 2'h0));

	always_ff @(posedge clk_sys) begin
		if (srst || full_tick) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + PRESCALE_W'(1);
		end
	end

	AST_HALF_TWICE: assert property (@(posedge clk_sys) disable iff (srst)
		(div_sel == 2'h1) && $stable(div_sel) && full_tick |=>
			((half_tick && !full_tick) || (div_sel != 2'h1)) ##1 (full_tick || (div_sel != 2'h1)))
		else $error("half tick not at twice the time-base rate");

endmodule
`default_nettype wire

// ===== rtl/edge_delay.sv
// one edge-delay path: postpones the active edge of src by count ticks
// assumes src is on clk_sys and tick is a one-cycle enable
`timescale 1ns/100ps
`default_nettype none
module edge_delay
	import dead_band_pkg::*;
#(
	parameter logic DELAY_FALL = 1'b0
) (
	input  wire logic             clk_sys, // system clock
	input  wire logic             srst,    // synchronous reset
	input  wire logic             tick,    // counter advance enable
	input  wire logic             src,     // selected source
	input  wire logic [CNT_W-1:0] count,   // delay in ticks
	output logic                  dly_out  // delayed signal
);

	logic             act;
	logic             prev_r;
	logic             out_act_r;
	logic [CNT_W-1:0] cnt_r;
	logic             reached;

	// the falling-edge path works on the inverted source
	assign act     = src ^ DELAY_FALL;
	assign reached = (act == prev_r) ? (cnt_r >= count) : (count == COUNT_RESET);
	assign dly_out = out_act_r ^ DELAY_FALL;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prev_r <= DELAY_FALL;
		end else begin
			prev_r <= act;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt_r <= COUNT_MAX;
		end else if (act != prev_r) begin
			// a tick in the edge cycle is the first delay period, so count n delays n periods
			cnt_r <= (act && tick) ? CNT_W'(1) : COUNT_RESET;
		end else if (act && tick && (cnt_r != COUNT_MAX)) begin
			cnt_r <= cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			out_act_r <= DELAY_FALL;
		end else begin
			out_act_r <= act && reached;
		end
	end

	AST_DLY_RELEASE: assert property (@(posedge clk_sys) disable iff (srst)
		!act |=> !out_act_r)
		else $error("inactive source edge not followed at once");
	AST_DLY_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(out_act_r) && (count >= 10'h002) |-> $past(act) && $past(act, 2) && $past(act, 3))
		else $error("delayed edge before count reached");

endmodule
`default_nettype wire

// ===== rtl/dead_band_gen.sv
// dead-band stage: source select, edge delays, output mode and inversion
// assumes in_a and in_b come from action-qualifier logic on clk_sys
//
// Notes on behaviour
// - The inputs are the two action-qualifier channel outputs, not counter or compare signals.
// - After reset channel A feeds both the leading-edge and trailing-edge delay paths.
// - Other source codes give A trailing/B leading, A leading/B trailing, and B to both.
// - Half-cycle clocking makes the delay counters advance at twice the time-base rate, except with divide by 1.
// - A two-bit output mode picks trailing delay, leading delay, neither or both.
// - Output mode 00 passes both inputs straight through, ignoring inversion.
// - A two-bit inversion field separately inverts the leading and trailing delayed signals.
// - With both delays, inversion 10 gives active-high and 01 active-low complementary pairs.
// - With both delays, inversion 00 gives an active-high and 11 an active-low pair.
// - Output mode 01 gives A undelayed and B from the trailing-edge path.
// - Output mode 10 gives A from the leading-edge path and B undelayed.
// - The two delay amounts sit in two independent count registers.
// - Each count is 10 bits and counts time-base periods.
// - In half-cycle clocking each delay is count times half a time-base period, or one period with divide by 1.
// - In normal clocking each delay is count times one prescaled time-base period.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module dead_band_gen
	import dead_band_pkg::*;
(
	input  wire logic              clk_sys,      // system clock, 250 MHz
	input  wire logic              srst,         // synchronous reset, active high
	input  wire logic              in_a,         // channel A from action qualifier
	input  wire logic              in_b,         // channel B from action qualifier
	input  wire logic [ADDR_W-1:0] reg_addr,     // register address
	input  wire logic [DATA_W-1:0] reg_wdata,    // write data
	input  wire logic              reg_wr,       // write strobe
	input  wire logic              reg_rd,       // read strobe
	output logic      [DATA_W-1:0] reg_rdata,    // read data, cycle after reg_rd
	output logic                   pwm_output_a, // output A
	output logic                   pwm_output_b  // output B
);

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [DATA_W-1:0] dead_band_control_r;
	logic [CNT_W-1:0]  leading_edge_delay_count_r;
	logic [CNT_W-1:0]  trailing_edge_delay_count_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              out_a_r;
	logic              out_b_r;
	logic              out_a_nxt;
	logic              out_b_nxt;

	logic [1:0]        out_mode;
	logic [1:0]        inversion_select;
	in_mode_t          in_mode;
	logic [1:0]        prescale;
	logic              half_cycle;

	assign out_mode         = dead_band_control_r[CTL_OUT_MODE_LSB +: 2];
	assign inversion_select = dead_band_control_r[CTL_INV_LSB +: 2];
	assign in_mode          = in_mode_t'(dead_band_control_r[CTL_IN_MODE_LSB +: 2]);
	assign prescale         = dead_band_control_r[CTL_PRESCALE_LSB +: 2];
	assign half_cycle       = dead_band_control_r[CTL_HALF_CYCLE];

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dead_band_control_r <= CTL_RESET;
		end else if (reg_wr && hit(reg_addr, OFF_CONTROL)) begin
			dead_band_control_r <= reg_wdata & CTL_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			leading_edge_delay_count_r <= COUNT_RESET;
		end else if (reg_wr && hit(reg_addr, OFF_LE_COUNT)) begin
			leading_edge_delay_count_r <= reg_wdata[CNT_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			trailing_edge_delay_count_r <= COUNT_RESET;
		end else if (reg_wr && hit(reg_addr, OFF_TE_COUNT)) begin
			trailing_edge_delay_count_r <= reg_wdata[CNT_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// time base and delay paths

	logic full_tick;
	logic half_tick;
	logic dly_tick;
	logic le_src;
	logic te_src;
	logic le_dly;
	logic te_dly;
	logic le_pol;
	logic te_pol;

	timebase_divider u_div (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.div_sel   (prescale),
		.full_tick (full_tick),
		.half_tick (half_tick)
	);

	// half-cycle mode doubles the counting rate, halving each count's weight, except with divide by 1
	assign dly_tick = half_cycle ? half_tick : full_tick;

	function automatic logic pick_src(input in_mode_t m, input logic a, input logic b,
		input logic leading);
		case (m)
			SRC_A_BOTH:    pick_src = a;
			SRC_B_LE_A_TE: pick_src = leading ? b : a;
			SRC_A_LE_B_TE: pick_src = leading ? a : b;
			SRC_B_BOTH:    pick_src = b;
			default:       pick_src = a;
		endcase
	endfunction

	assign le_src = pick_src(in_mode, in_a, in_b, 1'b1);
	assign te_src = pick_src(in_mode, in_a, in_b, 1'b0);

	edge_delay #(
		.DELAY_FALL (1'b0)
	) u_le (
		.clk_sys (clk_sys),
		.srst    (srst),
		.tick    (dly_tick),
		.src     (le_src),
		.count   (leading_edge_delay_count_r),
		.dly_out (le_dly)
	);

	edge_delay #(
		.DELAY_FALL (1'b1)
	) u_te (
		.clk_sys (clk_sys),
		.srst    (srst),
		.tick    (dly_tick),
		.src     (te_src),
		.count   (trailing_edge_delay_count_r),
		.dly_out (te_dly)
	);

	////////////////////////////////////////////////////////////////////////////
	// output mode and inversion

	assign le_pol = le_dly ^ inversion_select[0];
	assign te_pol = te_dly ^ inversion_select[1];

	always_comb begin
		out_a_nxt = in_a;
		out_b_nxt = in_b;
		case (out_mode)
			OUT_BYPASS: begin
				out_a_nxt = in_a;
				out_b_nxt = in_b;
			end
			OUT_TE_ONLY: begin
				out_a_nxt = in_a;
				out_b_nxt = te_pol;
			end
			OUT_LE_ONLY: begin
				out_a_nxt = le_pol;
				out_b_nxt = in_b;
			end
			OUT_BOTH: begin
				out_a_nxt = le_pol;
				out_b_nxt = te_pol;
			end
			default: begin
				out_a_nxt = in_a;
				out_b_nxt = in_b;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			out_a_r <= 1'b0;
			out_b_r <= 1'b0;
		end else begin
			out_a_r <= out_a_nxt;
			out_b_r <= out_b_nxt;
		end
	end

	assign pwm_output_a = out_a_r;
	assign pwm_output_b = out_b_r;

	////////////////////////////////////////////////////////////////////////////
	// read path: data only in the cycle after the strobe, zero otherwise

	always_comb begin
		rdata_nxt = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFF_CONTROL:  rdata_nxt = dead_band_control_r;
				OFF_LE_COUNT: rdata_nxt = DATA_W'(leading_edge_delay_count_r);
				OFF_TE_COUNT: rdata_nxt = DATA_W'(trailing_edge_delay_count_r);
				OFF_STATUS:   rdata_nxt = {12'h000, le_dly, te_dly, out_b_r, out_a_r};
				default:      rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////
	// checks

	AST_RESET_SRC: assert property (@(posedge clk_sys)
		srst |=> (in_mode == SRC_A_BOTH) && (out_mode == OUT_BYPASS))
		else $error("control not at default after reset");

	AST_SRC_DEFAULT: assert property (@(posedge clk_sys) disable iff (srst)
		(in_mode == SRC_A_BOTH) |-> (le_src == in_a) && (te_src == in_a))
		else $error("default source not channel A on both paths");

	AST_SRC_SWAP: assert property (@(posedge clk_sys) disable iff (srst)
		(in_mode == SRC_B_LE_A_TE) |-> (le_src == in_b) && (te_src == in_a))
		else $error("source code 01 routes wrong inputs");

	AST_BYPASS: assert property (@(posedge clk_sys) disable iff (srst)
		(out_mode == OUT_BYPASS) |=> (pwm_output_a == $past(in_a))
			&& (pwm_output_b == $past(in_b)))
		else $error("bypass mode does not pass inputs");

	AST_TE_ONLY: assert property (@(posedge clk_sys) disable iff (srst)
		(out_mode == OUT_TE_ONLY) |=> (pwm_output_a == $past(in_a))
			&& (pwm_output_b == $past(te_pol)))
		else $error("mode 01 outputs wrong");

	AST_LE_ONLY: assert property (@(posedge clk_sys) disable iff (srst)
		(out_mode == OUT_LE_ONLY) |=> (pwm_output_a == $past(le_pol))
			&& (pwm_output_b == $past(in_b)))
		else $error("mode 10 outputs wrong");

	AST_HIGH_COMPL: assert property (@(posedge clk_sys) disable iff (srst)
		(out_mode == OUT_BOTH) && (inversion_select == 2'h2) |=>
			(pwm_output_a == $past(le_dly)) && (pwm_output_b == !$past(te_dly)))
		else $error("active-high complementary pair wrong");

	AST_LOW_PAIR: assert property (@(posedge clk_sys) disable iff (srst)
		(out_mode == OUT_BOTH) && (inversion_select == 2'h3) |=>
			(pwm_output_a == !$past(le_dly)) && (pwm_output_b == !$past(te_dly)))
		else $error("active-low pair wrong");

	AST_COUNT_READ: assert property (@(posedge clk_sys) disable iff (srst)
		reg_rd && (reg_addr == OFF_LE_COUNT) |=>
			(reg_rdata[DATA_W-1:CNT_W] == '0) && (reg_rdata[CNT_W-1:0] == $past(leading_edge_delay_count_r)))
		else $error("leading count readback wrong");

	AST_TICK_SEL: assert property (@(posedge clk_sys) disable iff (srst)
		!half_cycle && half_tick && !full_tick |-> !dly_tick)
		else $error("normal clocking advanced on half tick");

	COV_BOTH: cover property (@(posedge clk_sys) disable iff (srst)
		(out_mode == OUT_BOTH) && $rose(pwm_output_a));
	COV_HALF: cover property (@(posedge clk_sys) disable iff (srst)
		half_cycle && $rose(le_dly));
	COV_SRC_B: cover property (@(posedge clk_sys) disable iff (srst)
		(in_mode == SRC_B_BOTH) && $fell(pwm_output_b));

endmodule
`default_nettype wire

// ===== tb/aq_source.sv
// partner model: action-qualifier stand-in making one pulse on each channel
// assumes start is a one-cycle strobe on clk_sys and lengths are held with it
`timescale 1ns/100ps
`default_nettype none
module aq_source (
	input  wire logic        clk_sys, // system clock
	input  wire logic        srst,    // synchronous reset
	input  wire logic        start,   // launch both pulses
	input  wire logic [11:0] len_a,   // channel a high cycles
	input  wire logic [11:0] len_b,   // channel b high cycles
	output logic             in_a,    // channel a level
	output logic             in_b     // channel b level
);
	logic [11:0] left_a_r;
	logic [11:0] left_b_r;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			left_a_r <= 12'h000;
			left_b_r <= 12'h000;
		end else if (start) begin
			left_a_r <= len_a;
			left_b_r <= len_b;
		end else begin
			left_a_r <= left_a_r - {11'h000, |left_a_r};
			left_b_r <= left_b_r - {11'h000, |left_b_r};
		end
	end

	// levels stand for the two channel outputs of the qualifier stage
	assign in_a = |left_a_r;
	assign in_b = |left_b_r;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// testbench: register access, bypass, pair modes, sources, clocking, short pulses
// assumes the qualifier stand-in drives both channel inputs
`timescale 1ns/100ps
`default_nettype none
module tb;
	import dead_band_pkg::*;
	logic              clk_sys   = 1'b0;
	logic              srst      = 1'b1;
	logic              in_a;
	logic              in_b;
	logic [ADDR_W-1:0] reg_addr  = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 16'h0000;
	logic              reg_wr    = 1'b0;
	logic              reg_rd    = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic              pwm_a;
	logic              pwm_b;
	logic              start     = 1'b0;
	logic [11:0]       len_a     = 12'h000;
	logic [11:0]       len_b     = 12'h000;
	int                fails     = 0;
	int                comparisons = 0;

	always #2 clk_sys = ~clk_sys;

	dead_band_gen DUT (.clk_sys(clk_sys), .srst(srst), .in_a(in_a), .in_b(in_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pwm_output_a(pwm_a), .pwm_output_b(pwm_b));
	aq_source partner (.clk_sys(clk_sys), .srst(srst), .start(start), .len_a(len_a),
		.len_b(len_b), .in_a(in_a), .in_b(in_b));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic near(input int seen, input int exp, input int tol);
		check({15'h0000, (seen >= exp - tol) && (seen <= exp + tol)}, 16'h0001);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	function automatic logic [15:0] ctl(input logic h, input logic [1:0] p,
		input logic [1:0] s, input logic [1:0] i, input logic [1:0] m);
		return {h, 7'h00, p, s, i, m};
	endfunction

	// launch one pulse per channel and count high cycles of each output
	task automatic run(input int la, input int lb, input int w, output int ha, output int hb);
		ha = 0;
		hb = 0;
		repeat (4) @(posedge clk_sys);
		start <= 1'b1;
		len_a <= 12'(la);
		len_b <= 12'(lb);
		@(posedge clk_sys);
		start <= 1'b0;
		repeat (w) begin
			@(posedge clk_sys);
			#1;
			// an unknown output spoils the count instead of passing as low
			ha += (pwm_a === 1'b1) ? 1 : ((pwm_a === 1'b0) ? 0 : 1000);
			hb += (pwm_b === 1'b1) ? 1 : ((pwm_b === 1'b0) ? 0 : 1000);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [15:0] d;
		check({14'h0000, pwm_a, pwm_b}, 16'h0000);
		rd(OFF_CONTROL, d);
		check(d, CTL_RESET);
		rd(OFF_LE_COUNT, d);
		check(d, 16'h0000);
		wr(OFF_LE_COUNT, 16'hfd55);
		wr(OFF_TE_COUNT, 16'h02aa);
		rd(OFF_LE_COUNT, d);
		check(d, 16'h0155);
		rd(OFF_TE_COUNT, d);
		check(d, 16'h02aa);
		wr(OFF_CONTROL, 16'hffff);
		rd(OFF_CONTROL, d);
		check(d, CTL_MASK);
		wr(OFF_CONTROL, 16'h0000);
		wr(8'h20, 16'h1234);
		rd(8'h20, d);
		check(d, 16'h0000);
		wr(OFF_STATUS, 16'hffff);
		rd(OFF_STATUS, d);
		check(d, 16'h0000);
		$display("test regs done");
	endtask

	task automatic t_bypass();
		int ha;
		int hb;
		wr(OFF_LE_COUNT, 16'h0032);
		wr(OFF_TE_COUNT, 16'h0032);
		wr(OFF_CONTROL, ctl(1'b0, 2'b00, SRC_A_BOTH, 2'b11, OUT_BYPASS));
		run(20, 10, 40, ha, hb);
		near(ha, 20, 0);
		near(hb, 10, 0);
		$display("test bypass done");
	endtask

	task automatic t_pairs();
		int ha;
		int hb;
		wr(OFF_LE_COUNT, 16'h0004);
		wr(OFF_TE_COUNT, 16'h0006);
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CONTROL, ctl(1'b0, 2'b00, SRC_A_BOTH, i[1:0], OUT_BOTH));
			run(30, 0, 70, ha, hb);
			near(ha, i[0] ? 44 : 26, 0);
			near(hb, i[1] ? 34 : 36, 0);
		end
		wr(OFF_CONTROL, ctl(1'b0, 2'b00, SRC_A_BOTH, 2'b00, OUT_TE_ONLY));
		run(30, 12, 70, ha, hb);
		near(ha, 30, 0);
		near(hb, 36, 0);
		wr(OFF_CONTROL, ctl(1'b0, 2'b00, SRC_A_BOTH, 2'b00, OUT_LE_ONLY));
		run(30, 12, 70, ha, hb);
		near(ha, 26, 0);
		near(hb, 12, 0);
		$display("test pairs done");
	endtask

	task automatic t_src();
		int ha;
		int hb;
		int ea[4] = '{26, 12, 26, 12};
		int eb[4] = '{36, 36, 22, 22};
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CONTROL, ctl(1'b0, 2'b00, i[1:0], 2'b00, OUT_BOTH));
			run(30, 16, 70, ha, hb);
			near(ha, ea[i], 0);
			near(hb, eb[i], 0);
		end
		$display("test sources done");
	endtask

	task automatic t_clock();
		int ha;
		int hb;
		wr(OFF_LE_COUNT, 16'h0014);
		wr(OFF_CONTROL, ctl(1'b0, 2'b10, SRC_A_BOTH, 2'b00, OUT_LE_ONLY));
		run(150, 0, 200, ha, hb);
		near(ha, 70, 7);
		wr(OFF_CONTROL, ctl(1'b1, 2'b10, SRC_A_BOTH, 2'b00, OUT_LE_ONLY));
		run(150, 0, 200, ha, hb);
		near(ha, 110, 7);
		wr(OFF_CONTROL, ctl(1'b0, 2'b01, SRC_A_BOTH, 2'b00, OUT_LE_ONLY));
		run(150, 0, 200, ha, hb);
		near(ha, 110, 3);
		wr(OFF_CONTROL, ctl(1'b1, 2'b11, SRC_A_BOTH, 2'b00, OUT_LE_ONLY));
		run(150, 0, 200, ha, hb);
		near(ha, 70, 7);
		$display("test clocking done");
	endtask

	task automatic t_short();
		int ha;
		int hb;
		wr(OFF_LE_COUNT, 16'h000a);
		wr(OFF_CONTROL, ctl(1'b0, 2'b00, SRC_A_BOTH, 2'b00, OUT_BOTH));
		run(8, 0, 40, ha, hb);
		near(ha, 0, 0);
		run(30, 0, 50, ha, hb);
		near(ha, 20, 0);
		near(hb, 36, 0);
		$display("test short pulses done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		t_regs();
		t_bypass();
		t_pairs();
		t_src();
		t_clock();
		t_short();
		end_of_test();
	end

	// whole run is near 1800 cycles
	initial begin
		repeat (8000) @(posedge clk_sys);
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
